//--- src/ria_pkg.sv
// Purpose: constants and types for the interrupt routing and day alarm block
// Assumes: AHB-Lite slave, 32-bit data, one word per register
// Notes: printed offsets are not multiples of four, so they are indices
// Contract
// - power fail with its enable set raises the interrupt and sets its flag
// - power fail with its enable clear sets its flag and leaves irq_pin low
// - alarm day register holds day of month as tens and units digits
// - bit 7 of alarm day register is the day mask bit
// - mask zero includes the day field in the match, one ignores it
package ria_pkg;
    localparam logic [15:0] IDX_ALARM_DAY = 16'h7FF5;
    localparam logic [15:0] IDX_IRQ_ROUTE = 16'h7FF6;
    localparam logic [15:0] IDX_FLAGS = 16'h7FE0;
    localparam logic [15:0] IDX_MASK = 16'h7FE1;
    localparam int DAY_MASK_BIT = 7;
    localparam int PFE_BIT = 5;
    localparam int AIE_BIT = 6;
    localparam int WIE_BIT = 7;
    localparam int FLAG_PF_BIT = 0;
    localparam int FLAG_AF_BIT = 1;
    localparam logic [7:0] ROUTE_WMASK = 8'hEC;
    localparam logic [7:0] DAY_WMASK = 8'hBF;
    localparam logic [7:0] FLAG_WMASK = 8'h03;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    typedef struct packed {
        logic [15:0] index;
        logic write;
        logic valid;
    } ria_req_t;

    typedef struct packed {
        logic mask;
        logic [5:0] day_bcd;
    } ria_day_t;
endpackage : ria_pkg

//--- src/ria_ctrl.sv
// Purpose: interrupt routing control and alarm day match, AHB-Lite slave
// Assumes: events are synchronised to hclk and come from other logic
// Notes: register byte address is four times its index
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/100ps
module ria_ctrl
    import ria_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic powerfail_event,
    input wire logic [5:0] cur_day_bcd,
    input wire logic alarm_tick,
    output logic irq_pin,
    output logic powerfail_flag,
    output logic alarm_flag,
    output logic irq
);
    ria_req_t req, next_req;
    logic [7:0] route, next_route;
    ria_day_t day, next_day;
    logic [7:0] flags, next_flags;
    logic [7:0] imask, next_imask;
    logic next_irq_pin, next_irq;
    logic [31:0] next_hrdata;
    logic match;

    function automatic logic [7:0] rd_byte(input logic [15:0] idx,
        input logic [7:0] rt, input ria_day_t d, input logic [7:0] fl,
        input logic [7:0] mk);
        case (idx)
            IDX_IRQ_ROUTE: rd_byte = rt;
            IDX_ALARM_DAY: rd_byte = {d.mask, 1'b0, d.day_bcd};
            IDX_FLAGS: rd_byte = fl;
            IDX_MASK: rd_byte = mk;
            default: rd_byte = RST_BYTE;
        endcase
    endfunction : rd_byte

    // masked field always matches; day compared as bcd digits
    assign match = alarm_tick
        && (day.mask || day.day_bcd == cur_day_bcd);

    always_comb begin
        next_req.valid = hsel && hready && htrans[1];
        next_req.write = hwrite;
        next_req.index = haddr[17:2];
        next_route = route;
        next_day = day;
        next_imask = imask;
        next_flags = flags;
        if (req.valid && req.write) begin
            case (req.index)
                IDX_IRQ_ROUTE: next_route = hwdata[7:0] & ROUTE_WMASK;
                IDX_ALARM_DAY: next_day = ria_day_t'({hwdata[7], hwdata[5:0]});
                IDX_MASK: next_imask = hwdata[7:0] & FLAG_WMASK;
                IDX_FLAGS: next_flags = flags & ~(hwdata[7:0] & FLAG_WMASK);
                default: next_flags = flags;
            endcase
        end
        // set wins over a same-cycle clear
        if (powerfail_event) begin
            next_flags[FLAG_PF_BIT] = 1'b1;
        end
        if (match) begin
            next_flags[FLAG_AF_BIT] = 1'b1;
        end
        // pin follows only enabled sources; flags are set regardless
        next_irq_pin = (route[PFE_BIT] && next_flags[FLAG_PF_BIT])
            || (route[AIE_BIT] && next_flags[FLAG_AF_BIT]);
        next_irq = |(next_flags & next_imask);
        next_hrdata = 32'h0000_0000;
        if (next_req.valid && !hwrite) begin
            next_hrdata[7:0] = rd_byte(haddr[17:2], next_route, next_day,
                next_flags, next_imask);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req <= '0;
            route <= RST_BYTE;
            day <= '0;
            flags <= RST_BYTE;
            imask <= RST_BYTE;
            irq_pin <= 1'b0;
            irq <= 1'b0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            powerfail_flag <= 1'b0;
            alarm_flag <= 1'b0;
        end else begin
            req <= next_req;
            route <= next_route;
            day <= next_day;
            flags <= next_flags;
            imask <= next_imask;
            irq_pin <= next_irq_pin;
            irq <= next_irq;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            powerfail_flag <= next_flags[FLAG_PF_BIT];
            alarm_flag <= next_flags[FLAG_AF_BIT];
        end
    end

    AST_PF_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
        powerfail_event |=> powerfail_flag)
        else $error("power fail did not set flag");
    AST_PF_PIN: assert property (@(posedge hclk) disable iff (!hresetn)
        powerfail_event && route[PFE_BIT] |=> irq_pin)
        else $error("enabled power fail did not raise pin");
    AST_PF_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_pin |-> $past(route[PFE_BIT] && flags[FLAG_PF_BIT]
            || route[AIE_BIT] && flags[FLAG_AF_BIT])
            || $past(powerfail_event || match))
        else $error("pin raised without enabled source");
    AST_MASK_MATCH: assert property (@(posedge hclk) disable iff (!hresetn)
        alarm_tick && day.mask |=> alarm_flag)
        else $error("masked day did not match");
    AST_DAY_CMP: assert property (@(posedge hclk) disable iff (!hresetn)
        alarm_tick && !day.mask && day.day_bcd == cur_day_bcd |=> alarm_flag)
        else $error("day equal but no alarm");
    AST_DAY_MISS: assert property (@(posedge hclk) disable iff (!hresetn)
        !day.mask && day.day_bcd != cur_day_bcd |-> !match)
        else $error("unmasked day mismatch matched");
    AST_AL_PIN: assert property (@(posedge hclk) disable iff (!hresetn)
        match && route[AIE_BIT] |=> irq_pin && alarm_flag)
        else $error("enabled alarm did not raise pin");
    AST_READY: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("slave not ready or error");

    // bus write strobes as the data phase lands; the checks below use them
    // to tell a software clear from a flag or setting that moved by itself
    logic req_wr;
    logic wr_flags;
    logic wr_mask;
    logic wr_day;
    logic wr_route;
    assign req_wr = req.valid && req.write;
    assign wr_flags = req_wr && req.index == IDX_FLAGS;
    assign wr_mask = req_wr && req.index == IDX_MASK;
    assign wr_day = req_wr && req.index == IDX_ALARM_DAY;
    assign wr_route = req_wr && req.index == IDX_IRQ_ROUTE;

    // flag behaviour: set by the source, held until a one is written back
    AST_AF_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
        match |=> alarm_flag)
        else $error("alarm match did not set flag");

    AST_PF_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
        powerfail_flag && !(wr_flags && hwdata[FLAG_PF_BIT]) |=> powerfail_flag)
        else $error("power fail flag dropped without clear");

    AST_AF_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
        alarm_flag && !(wr_flags && hwdata[FLAG_AF_BIT]) |=> alarm_flag)
        else $error("alarm flag dropped without clear");

    AST_PF_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_flags && hwdata[FLAG_PF_BIT] && !powerfail_event |=> !powerfail_flag)
        else $error("power fail flag not cleared");

    AST_AF_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_flags && hwdata[FLAG_AF_BIT] && !match |=> !alarm_flag)
        else $error("alarm flag not cleared");

    // pin routing: a disabled source must never reach the pin
    AST_PIN_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        !route[PFE_BIT] && !route[AIE_BIT] |=> !irq_pin)
        else $error("pin raised with both sources disabled");

    AST_PIN_PF_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        route[PFE_BIT] && powerfail_flag && !wr_flags && !wr_route |=> irq_pin)
        else $error("pin fell while power fail flag set");

    AST_PIN_AL_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        route[AIE_BIT] && alarm_flag && !wr_flags && !wr_route |=> irq_pin)
        else $error("pin fell while alarm flag set");

    AST_ROUTE_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
        !wr_route |=> $stable(route))
        else $error("route changed without write");

    AST_WR_ROUTE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_route |=> route == ($past(hwdata[7:0]) & ROUTE_WMASK))
        else $error("route write not stored");

    // alarm day register keeps the mask bit and day digits that software wrote; bit 6 is not stored
    AST_DAY_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        !wr_day |=> $stable(day))
        else $error("alarm day changed without write");

    AST_DAY_MASK: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_day |=> day.mask == $past(hwdata[DAY_MASK_BIT]))
        else $error("day mask bit not stored");

    AST_DAY_DIGITS: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_day |=> day.day_bcd == $past(hwdata[$bits(day.day_bcd)-1:0]))
        else $error("day digits not stored");

    // summary interrupt follows the mask, whatever the pin routing says
    AST_IRQ_PF: assert property (@(posedge hclk) disable iff (!hresetn)
        powerfail_event && imask[FLAG_PF_BIT] && !wr_mask |=> irq)
        else $error("unmasked power fail gave no irq");

    AST_IRQ_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        imask == RST_BYTE && !wr_mask |=> !irq)
        else $error("irq raised with all sources masked");
endmodule : ria_ctrl

//--- tb/ria_ctrl_tb_top.sv
// Purpose: bench for interrupt routing and alarm day register block
// Assumes: zero wait slave, byte address is four times the index
// Notes: flags and mask indices are the ones chosen in the package
`timescale 1ns/100ps
module ria_ctrl_tb_top;
    import ria_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, irq_pin;
    logic powerfail_event, alarm_tick, powerfail_flag, alarm_flag;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [5:0] cur_day_bcd;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    ria_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .powerfail_event(powerfail_event), .cur_day_bcd(cur_day_bcd),
        .alarm_tick(alarm_tick), .irq_pin(irq_pin),
        .powerfail_flag(powerfail_flag), .alarm_flag(alarm_flag), .irq(irq));
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask : chk
    // one single transfer; waits on hready, never on a fixed count
    task automatic bus(input logic [15:0] idx, input logic w, logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {14'h0, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rdchk(input logic [15:0] idx, input logic [7:0] e);
        bus(idx, 1'b0, 8'h00);
        chk("rdata", {24'h0, e}, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : rdchk
    // pulses one source, then looks at {irq_pin, pf flag, alarm flag}
    task automatic fire(input logic pf, logic [5:0] day, logic [2:0] e);
        cur_day_bcd <= day;
        powerfail_event <= pf;
        alarm_tick <= !pf;
        @(posedge hclk);
        powerfail_event <= 1'b0;
        alarm_tick <= 1'b0;
        @(posedge hclk);
        #1;
        chk("outs", {29'h0, e}, {29'h0, irq_pin, powerfail_flag, alarm_flag});
        @(posedge hclk);
    endtask : fire
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
        {powerfail_event, alarm_tick, cur_day_bcd} = '0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(IDX_IRQ_ROUTE, RST_BYTE);
        bus(IDX_IRQ_ROUTE, 1'b1, 8'hFF);
        rdchk(IDX_IRQ_ROUTE, ROUTE_WMASK);
        rdchk(16'h0100, 8'h00);
        bus(IDX_IRQ_ROUTE, 1'b1, 8'h20);
        fire(1'b1, 6'h00, 3'b110);
        bus(IDX_FLAGS, 1'b1, 8'h03);
        fire(1'b0, 6'h00, 3'b001);
        bus(IDX_IRQ_ROUTE, 1'b1, 8'h00);
        fire(1'b1, 6'h00, 3'b011);
        bus(IDX_FLAGS, 1'b1, 8'h03);
        bus(IDX_ALARM_DAY, 1'b1, 8'h31);
        rdchk(IDX_ALARM_DAY, 8'h31);
        bus(IDX_IRQ_ROUTE, 1'b1, 8'h40);
        fire(1'b0, 6'h31, 3'b101);
        bus(IDX_FLAGS, 1'b1, 8'h03);
        fire(1'b0, 6'h12, 3'b000);
        bus(IDX_ALARM_DAY, 1'b1, 8'hFF);
        rdchk(IDX_ALARM_DAY, DAY_WMASK);
        fire(1'b0, 6'h12, 3'b101);
        bus(IDX_MASK, 1'b1, 8'h02);
        #1 chk("irq", 32'h1, {31'h0, irq});
        bus(IDX_FLAGS, 1'b1, 8'h03);
        @(posedge hclk);
        #1 chk("irq", 32'h0, {31'h0, irq});
        bus(IDX_IRQ_ROUTE, 1'b1, 8'h00);
        fire(1'b0, 6'h12, 3'b001);
        test_done();
    end
endmodule : ria_ctrl_tb_top
